// ==== core/acx_consts.svh ====
/*
 * constants of the accumulator command unit: frame layout, opcodes,
 * operation and flag selectors, status codes, register map.
 * assumes inclusion by bare name; guarded against repeated inclusion in one compile unit.
 */
`ifndef ACX_CONSTS_SVH
`define ACX_CONSTS_SVH

// ****************************************
// frame
// ****************************************
`define ACX_FRAME_LEN 4'h9
`define ACX_LAST_BYTE 4'h8

// ****************************************
// opcodes and selectors
// ****************************************
`define ACX_OP_XCALC 8'h21
`define ACX_OP_AXP 8'h22
`define ACX_OP_GLP 8'h23
`define ACX_OP_CLE 8'h24
`define ACX_T_ADD 8'h00
`define ACX_T_SUB 8'h01
`define ACX_T_MUL 8'h02
`define ACX_T_DIV 8'h03
`define ACX_T_MOD 8'h04
`define ACX_T_AND 8'h05
`define ACX_T_OR 8'h06
`define ACX_T_XOR 8'h07
`define ACX_T_NOT 8'h08
`define ACX_T_LOAD 8'h09
`define ACX_T_SWAP 8'h0A
`define ACX_CLE_ALL 8'h00
`define ACX_CLE_MAX 8'h05

// ****************************************
// reply status codes
// ****************************************
`define ACX_ST_OK 8'h64
`define ACX_ST_CSUM 8'h01
`define ACX_ST_BADOP 8'h02
`define ACX_ST_BADTYPE 8'h03

// ****************************************
// register map (byte addresses) and resets
// ****************************************
`define ACX_R_CTRL 5'h00
`define ACX_R_ACCU 5'h04
`define ACX_R_XREG 5'h08
`define ACX_R_ERRF 5'h0C
`define ACX_R_ISTAT 5'h10
`define ACX_R_IMASK 5'h14
`define ACX_R_STATE 5'h18
`define ACX_CTRL_RST 16'h0201
`define ACX_IRQ_DONE 0
`define ACX_IRQ_CSUM 1
`define ACX_IRQ_BAD 2
`define ACX_IRQ_DIVZ 3

`endif

// ==== core/acx_pkg.sv ====
/*
 * types of the accumulator command unit.
 * assumes nothing beyond a sv compiler.
 */
package acx_pkg;
    typedef enum logic [1:0] {
        ACX_IDLE,
        ACX_EXEC,
        ACX_REPLY
    } acx_state_e;
    typedef logic [7:0] acx_byte_t;
endpackage

// ==== core/acx_core.sv ====
/*
 * accumulator / x-register command unit: frame receiver, executor,
 * reply sender, error flags, wishbone classic register slave.
 * assumes rx bytes and program commands come from logic on clk_i,
 * and that parameter stores accept one write pulse per cycle.
 */
// Decided for this implementation: the address map and register access over Wishbone.
// Behaviour
// - type 0-4: add sub mul div mod
// - type 5-7: and, or, xor with x
// - type 8: invert x register value
// - type 9: copy accu into x
// - type 10: swap accu and x
// - other results land in the accumulator
// - opcode 34: accu to axis parameter
// - opcode 35: accu to global parameter
// - opcode 36 clears error flags by type
// - type 0 all, 1-5 one flag each
`timescale 1ns/1ps
`include "acx_consts.svh"

module acx_core
    import acx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic pgm_valid_i,
    input wire logic [7:0] pgm_instr_i,
    input wire logic [7:0] pgm_type_i,
    input wire logic [7:0] pgm_bank_i,
    output logic pgm_ready_o,
    input wire logic accu_load_i,
    input wire logic [31:0] accu_load_val_i,
    output logic ap_wr_o,
    output logic [7:0] ap_num_o,
    output logic [7:0] ap_motor_o,
    output logic gp_wr_o,
    output logic [7:0] gp_num_o,
    output logic [7:0] gp_bank_o,
    output logic [31:0] par_data_o,
    input wire logic [4:0] err_set_i,
    output logic [4:0] err_flags_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);

    // ****************************************
    // storage and state
    // ****************************************
    acx_state_e state;
    acx_byte_t rx_buf [0:8];
    acx_byte_t tx_buf [0:8];
    logic [3:0] rx_idx;
    logic [3:0] tx_idx;
    logic rx_done;
    logic [7:0] c_instr;
    logic [7:0] c_type;
    logic [7:0] c_bank;
    logic c_direct;
    logic c_csum_bad;
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [15:0] ctrl;
    logic [3:0] istat;
    logic [3:0] imask;
    logic [7:0] last_status;
    logic [31:0] next_accu;
    logic [31:0] next_x;
    logic [7:0] next_status;
    logic next_divz;
    logic [4:0] next_clr;
    logic [63:0] prod;
    logic wb_req;
    logic wb_wr;
    logic [3:0] evt;

    // sum of the first eight bytes, used on receive and on reply
    function automatic logic [7:0] acx_sum8(input acx_byte_t b [0:8]);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + b[i];
        end
        return s;
    endfunction

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] acx_merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;
    assign prod = $signed(accu) * $signed(xreg);

    // ****************************************
    // frame receiver
    // ****************************************
    // bytes that arrive while busy are still collected; the host waits for a reply
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_idx <= 4'h0;
            rx_done <= 1'b0;
        end else begin
            if (state == ACX_IDLE) begin
                rx_done <= 1'b0;
            end
            if (rx_valid_i) begin
                rx_buf[rx_idx] <= rx_byte_i;
                if (rx_idx == `ACX_LAST_BYTE) begin
                    rx_idx <= 4'h0;
                    rx_done <= 1'b1;
                end else begin
                    rx_idx <= rx_idx + 4'h1;
                end
            end
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    // direct frames win over the stored program when both are ready
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ACX_IDLE;
            c_instr <= 8'h00;
            c_type <= 8'h00;
            c_bank <= 8'h00;
            c_direct <= 1'b0;
            c_csum_bad <= 1'b0;
            pgm_ready_o <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            tx_idx <= 4'h0;
            last_status <= `ACX_ST_OK;
        end else begin
            pgm_ready_o <= 1'b0;
            case (state)
                ACX_IDLE: begin
                    if (rx_done && rx_buf[0] == ctrl[7:0]) begin
                        c_instr <= rx_buf[1];
                        c_type <= rx_buf[2];
                        c_bank <= rx_buf[3];
                        c_direct <= 1'b1;
                        c_csum_bad <= acx_sum8(rx_buf) != rx_buf[8];
                        state <= ACX_EXEC;
                    end else if (pgm_valid_i && pgm_ready_o) begin
                        c_instr <= pgm_instr_i;
                        c_type <= pgm_type_i;
                        c_bank <= pgm_bank_i;
                        c_direct <= 1'b0;
                        c_csum_bad <= 1'b0;
                        state <= ACX_EXEC;
                    end else begin
                        pgm_ready_o <= !rx_done && !(rx_valid_i && rx_idx == `ACX_LAST_BYTE);
                    end
                end
                ACX_EXEC: begin
                    last_status <= next_status;
                    state <= c_direct ? ACX_REPLY : ACX_IDLE;
                    tx_idx <= 4'h0;
                end
                ACX_REPLY: begin
                    if (!tx_valid_o) begin
                        tx_valid_o <= 1'b1;
                        tx_byte_o <= tx_buf[0];
                    end else if (tx_ready_i) begin
                        if (tx_idx == `ACX_LAST_BYTE) begin
                            tx_valid_o <= 1'b0;
                            state <= ACX_IDLE;
                        end else begin
                            tx_byte_o <= tx_buf[tx_idx + 4'h1];
                        end
                        tx_idx <= tx_idx + 4'h1;
                    end
                end
                default: state <= ACX_IDLE;
            endcase
        end
    end

    // reply frame: host addr, module addr, status, opcode, accu, sum
    always_ff @(posedge clk_i) begin
        if (state == ACX_EXEC) begin
            tx_buf[0] <= ctrl[15:8];
            tx_buf[1] <= ctrl[7:0];
            tx_buf[2] <= next_status;
            tx_buf[3] <= c_instr;
            tx_buf[4] <= next_accu[31:24];
            tx_buf[5] <= next_accu[23:16];
            tx_buf[6] <= next_accu[15:8];
            tx_buf[7] <= next_accu[7:0];
        end else if (state == ACX_REPLY && !tx_valid_o) begin
            tx_buf[8] <= acx_sum8(tx_buf);
        end
    end

    // ****************************************
    // executor
    // ****************************************
    // divide by zero leaves both registers alone rather than inventing a value
    always_comb begin
        next_accu = accu;
        next_x = xreg;
        next_status = `ACX_ST_OK;
        next_divz = 1'b0;
        next_clr = 5'h00;
        if (c_csum_bad) begin
            next_status = `ACX_ST_CSUM;
        end else begin
            case (c_instr)
                `ACX_OP_XCALC: begin
                    case (c_type)
                        `ACX_T_ADD: next_accu = accu + xreg;
                        `ACX_T_SUB: next_accu = accu - xreg;
                        `ACX_T_MUL: next_accu = prod[31:0];
                        `ACX_T_DIV: begin
                            next_divz = xreg == 32'h00000000;
                            if (!next_divz) begin
                                next_accu = $signed(accu) / $signed(xreg);
                            end
                        end
                        `ACX_T_MOD: begin
                            next_divz = xreg == 32'h00000000;
                            if (!next_divz) begin
                                next_accu = $signed(accu) % $signed(xreg);
                            end
                        end
                        `ACX_T_AND: next_accu = accu & xreg;
                        `ACX_T_OR: next_accu = accu | xreg;
                        `ACX_T_XOR: next_accu = accu ^ xreg;
                        `ACX_T_NOT: next_accu = ~xreg;
                        `ACX_T_LOAD: next_x = accu;
                        `ACX_T_SWAP: begin
                            next_accu = xreg;
                            next_x = accu;
                        end
                        default: next_status = `ACX_ST_BADTYPE;
                    endcase
                end
                `ACX_OP_AXP, `ACX_OP_GLP: next_status = `ACX_ST_OK;
                `ACX_OP_CLE: begin
                    if (c_type == `ACX_CLE_ALL) begin
                        next_clr = 5'h1F;
                    end else if (c_type <= `ACX_CLE_MAX) begin
                        next_clr = 5'h01 << (c_type[2:0] - 3'h1);
                    end else begin
                        next_status = `ACX_ST_BADTYPE;
                    end
                end
                default: next_status = `ACX_ST_BADOP;
            endcase
        end
    end

    // parameter write pulses; the stored accu is what the caller prepared
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ap_wr_o <= 1'b0;
            gp_wr_o <= 1'b0;
            ap_num_o <= 8'h00;
            ap_motor_o <= 8'h00;
            gp_num_o <= 8'h00;
            gp_bank_o <= 8'h00;
            par_data_o <= 32'h00000000;
        end else begin
            ap_wr_o <= state == ACX_EXEC && !c_csum_bad && c_instr == `ACX_OP_AXP;
            gp_wr_o <= state == ACX_EXEC && !c_csum_bad && c_instr == `ACX_OP_GLP;
            if (state == ACX_EXEC) begin
                ap_num_o <= c_type;
                ap_motor_o <= c_bank;
                gp_num_o <= c_type;
                gp_bank_o <= c_bank;
                par_data_o <= accu;
            end
        end
    end

    // accumulator and x: execution beats external load beats bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accu <= 32'h00000000;
            xreg <= 32'h00000000;
        end else if (state == ACX_EXEC) begin
            accu <= next_accu;
            xreg <= next_x;
        end else begin
            if (accu_load_i) begin
                accu <= accu_load_val_i;
            end else if (wb_wr && wb_adr_i == `ACX_R_ACCU) begin
                accu <= acx_merge(accu, wb_dat_i, wb_sel_i);
            end
            if (wb_wr && wb_adr_i == `ACX_R_XREG) begin
                xreg <= acx_merge(xreg, wb_dat_i, wb_sel_i);
            end
        end
    end

    // ****************************************
    // error flags and interrupts
    // ****************************************
    // a flag raised in the cycle of its clear stays set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_flags_o <= 5'h00;
        end else begin
            err_flags_o <= (err_flags_o
                & ~((state == ACX_EXEC) ? next_clr : 5'h00)
                & ~((wb_wr && wb_adr_i == `ACX_R_ERRF && wb_sel_i[0]) ? wb_dat_i[4:0] : 5'h00))
                | err_set_i;
        end
    end

    assign evt = {state == ACX_EXEC && next_divz,
        state == ACX_EXEC && next_status != `ACX_ST_OK && !c_csum_bad,
        state == ACX_EXEC && c_csum_bad,
        state == ACX_EXEC};

    // sticky events, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat <= 4'h0;
            irq_o <= 1'b0;
        end else begin
            istat <= (istat & ~((wb_wr && wb_adr_i == `ACX_R_ISTAT && wb_sel_i[0])
                ? wb_dat_i[3:0] : 4'h0)) | evt;
            irq_o <= |(istat & imask);
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    // one wait state: ack one cycle after the request, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl <= `ACX_CTRL_RST;
            imask <= 4'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_wr && wb_adr_i == `ACX_R_CTRL) begin
                ctrl <= 16'(acx_merge({16'h0000, ctrl}, wb_dat_i, wb_sel_i));
            end
            if (wb_wr && wb_adr_i == `ACX_R_IMASK && wb_sel_i[0]) begin
                imask <= wb_dat_i[3:0];
            end
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `ACX_R_CTRL: wb_dat_o <= {16'h0000, ctrl};
                    `ACX_R_ACCU: wb_dat_o <= accu;
                    `ACX_R_XREG: wb_dat_o <= xreg;
                    `ACX_R_ERRF: wb_dat_o <= {27'h0000000, err_flags_o};
                    `ACX_R_ISTAT: wb_dat_o <= {28'h0000000, istat};
                    `ACX_R_IMASK: wb_dat_o <= {28'h0000000, imask};
                    `ACX_R_STATE: wb_dat_o <= {22'h000000, state, last_status};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ==== dv/acx_host_model.sv ====
/*
 * host model: sends nine byte command frames into the rx port and takes reply bytes.
 * assumes it shares clk_i with the command unit.
 */
`timescale 1ns/1ps
module acx_host_model (
    input wire logic clk_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    logic [7:0] rep [0:8];
    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
    end
    // one idle cycle per byte; idle byte is inverted so a stale byte never looks fresh
    task send(input logic [7:0] i, input logic [7:0] t, input logic [7:0] b, input logic [31:0] v, input logic bad);
        logic [7:0] f [0:8];
        f = '{8'h01, i, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        for (int k = 0; k < 8; k++) begin
            f[8] = f[8] + f[k];
        end
        f[8] = f[8] + {7'h00, bad}; // corrupt sum on request
        for (int k = 0; k < 9; k++) begin
            @(posedge clk_i);
            rx_byte_o <= f[k];
            rx_valid_o <= 1'b1;
            @(posedge clk_i);
            rx_byte_o <= ~f[k];
            rx_valid_o <= 1'b0;
        end
    endtask
    // takes nine reply bytes, stalling before each one
    task recv(input int stall);
        for (int k = 0; k < 9; k++) begin
            if (stall != 0) begin
                tx_ready_o <= 1'b0;
                repeat (stall) @(posedge clk_i);
            end
            tx_ready_o <= 1'b1;
            do @(posedge clk_i); while (tx_valid_i !== 1'b1);
            rep[k] = tx_byte_i;
        end
        tx_ready_o <= 1'b0;
    endtask
endmodule

// ==== dv/acx_core_monitor.sv ====
/*
 * checker of the accumulator command unit, bound to acx_core.
 * assumes one clock domain and synchronous active high reset.
 */
`timescale 1ns/1ps
`include "acx_consts.svh"
module acx_core_monitor (
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic [7:0] tx_byte_o,
    input logic tx_valid_o,
    input logic tx_ready_i,
    input logic pgm_valid_i,
    input logic pgm_ready_o,
    input logic [7:0] pgm_instr_i,
    input logic [7:0] pgm_type_i,
    input logic [7:0] pgm_bank_i,
    input logic ap_wr_o,
    input logic [7:0] ap_num_o,
    input logic [7:0] ap_motor_o,
    input logic gp_wr_o,
    input logic [7:0] gp_num_o,
    input logic [7:0] gp_bank_o,
    input logic [4:0] err_set_i,
    input logic [4:0] err_flags_o,
    input logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // properties
    // ****************************************
    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_tx_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("reply byte changed before taken");
    a_pgm_axis_write: assert property (pgm_valid_i && pgm_ready_o && pgm_instr_i == `ACX_OP_AXP |->
        ##2 ap_wr_o && ap_num_o == $past(pgm_type_i, 2) && ap_motor_o == $past(pgm_bank_i, 2))
        else $error("axis write missing or wrong selector");
    a_pgm_global_write: assert property (pgm_valid_i && pgm_ready_o && pgm_instr_i == `ACX_OP_GLP |->
        ##2 gp_wr_o && gp_num_o == $past(pgm_type_i, 2) && gp_bank_o == $past(pgm_bank_i, 2))
        else $error("global write missing or wrong selector");
    a_write_exclusive: assert property (!(ap_wr_o && gp_wr_o) && !(ap_wr_o && $past(ap_wr_o)))
        else $error("parameter writes overlap");
    a_flag_set_wins: assert property (err_set_i != 5'h00 |=> (err_flags_o & $past(err_set_i)) == $past(err_set_i))
        else $error("error flag not set");
    a_flag_no_cause: assert property ((err_flags_o & ~$past(err_flags_o) & ~$past(err_set_i)) == 5'h00)
        else $error("error flag set without cause");
    c_axis: cover property (ap_wr_o);
    c_global: cover property (gp_wr_o);
    c_reply: cover property (tx_valid_o && tx_ready_i);
    c_irq: cover property (irq_o);
endmodule
bind acx_core acx_core_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .pgm_valid_i(pgm_valid_i), .pgm_ready_o(pgm_ready_o), .pgm_instr_i(pgm_instr_i), .pgm_type_i(pgm_type_i),
    .pgm_bank_i(pgm_bank_i), .ap_wr_o(ap_wr_o), .ap_num_o(ap_num_o), .ap_motor_o(ap_motor_o), .gp_wr_o(gp_wr_o),
    .gp_num_o(gp_num_o), .gp_bank_o(gp_bank_o), .err_set_i(err_set_i), .err_flags_o(err_flags_o), .irq_o(irq_o));

// ==== dv/tb_accumulator_immediate_a_command_set.sv ====
/*
 * self-checking bench of acx_core: frames from the host model, wishbone tasks, program port.
 * assumes acx_consts.svh on the include path and the bound checker.
 */
`timescale 1ns/1ps
`include "acx_consts.svh"
module tb_accumulator_immediate_a_command_set;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pgm_valid_i = 1'b0;
    logic [7:0] pgm_instr_i = 8'h00, pgm_type_i = 8'h00, pgm_bank_i = 8'h00, rx_byte_i, tx_byte_o;
    logic accu_load_i = 1'b0;
    logic [31:0] accu_load_val_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, par_data_o, rd, cap_dat;
    logic [4:0] err_set_i = 5'h00, wb_adr_i = 5'h00, err_flags_o;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, rx_valid_i, tx_ready_i, tx_valid_o;
    logic pgm_ready_o, ap_wr_o, gp_wr_o, wb_ack_o, irq_o;
    logic [3:0] wb_sel_i = 4'hF;
    logic [7:0] ap_num_o, ap_motor_o, gp_num_o, gp_bank_o;
    logic [17:0] cap_sel;
    int fails = 0, total_checks = 0, cycles = 0;
    acx_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
        .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .pgm_valid_i(pgm_valid_i),
        .pgm_instr_i(pgm_instr_i), .pgm_type_i(pgm_type_i), .pgm_bank_i(pgm_bank_i), .pgm_ready_o(pgm_ready_o),
        .accu_load_i(accu_load_i), .accu_load_val_i(accu_load_val_i), .ap_wr_o(ap_wr_o), .ap_num_o(ap_num_o),
        .ap_motor_o(ap_motor_o), .gp_wr_o(gp_wr_o), .gp_num_o(gp_num_o), .gp_bank_o(gp_bank_o),
        .par_data_o(par_data_o), .err_set_i(err_set_i), .err_flags_o(err_flags_o), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    acx_host_model u_host (.clk_i(clk_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i), .tx_byte_i(tx_byte_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
    // ****************************************
    // clock, capture, watchdog
    // ****************************************
    always #2.5 clk_i = ~clk_i;
    // last parameter write, kind in the top bits
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ap_wr_o) begin
            cap_sel <= {2'h1, ap_num_o, ap_motor_o};
            cap_dat <= par_data_o;
        end
        if (gp_wr_o) begin
            cap_sel <= {2'h2, gp_num_o, gp_bank_o};
            cap_dat <= par_data_o;
        end
    end
    // generous ceiling, the tests need little more than a thousand cycles
    always @(posedge clk_i) begin
        if (cycles == 20000) begin
            fails = fails + 1;
            end_sim();
        end
    end
    task end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // frame out, reply back and judged
    task cmd(input logic [7:0] i, t, b, input logic bad, input int stall, input logic [7:0] st, input logic [31:0] acc);
        logic [7:0] s;
        s = 8'h00;
        u_host.send(i, t, b, 32'h1234_5678, bad);
        u_host.recv(stall);
        for (int k = 0; k < 8; k++) s = s + u_host.rep[k];
        chk({u_host.rep[0], u_host.rep[1], u_host.rep[2], u_host.rep[3]}, {8'h02, 8'h01, st, i});
        chk({u_host.rep[4], u_host.rep[5], u_host.rep[6], u_host.rep[7]}, acc);
        chk({24'h0, u_host.rep[8]}, {24'h0, s});
    endtask
    task pgm(input logic [7:0] i, t, b);
        @(posedge clk_i);
        pgm_valid_i <= 1'b1;
        pgm_instr_i <= i;
        pgm_type_i <= t;
        pgm_bank_i <= b;
        do @(posedge clk_i); while (pgm_ready_o !== 1'b1);
        pgm_valid_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        wb(1'b0, `ACX_R_CTRL, 32'h0);
        chk(rd, {16'h0, `ACX_CTRL_RST});
        wb(1'b0, 5'h1C, 32'h0);
        chk(rd, 32'h0);
        chk({27'h0, err_flags_o}, 32'h0);
    endtask
    task t_xcalc;
        logic [31:0] ea [0:10];
        logic [31:0] ex [0:10];
        ea = '{32'h6B, 32'h5D, 32'h2BC, 32'hE, 32'h2, 32'h4, 32'h67, 32'h63, 32'hFFFF_FFF8, 32'h64, 32'h7};
        ex = '{32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h7, 32'h64, 32'h64};
        for (int k = 0; k < 11; k++) begin
            wb(1'b1, `ACX_R_ACCU, 32'h64);
            wb(1'b1, `ACX_R_XREG, 32'h7);
            cmd(`ACX_OP_XCALC, k[7:0], 8'h5A, 1'b0, k % 3, `ACX_ST_OK, ea[k]);
            wb(1'b0, `ACX_R_ACCU, 32'h0);
            chk(rd, ea[k]);
            wb(1'b0, `ACX_R_XREG, 32'h0);
            chk(rd, ex[k]);
        end
    endtask
    task t_refused;
        wb(1'b1, `ACX_R_ACCU, 32'h55);
        cmd(`ACX_OP_XCALC, `ACX_T_ADD, 8'h00, 1'b1, 0, `ACX_ST_CSUM, 32'h55);
        cmd(`ACX_OP_XCALC, 8'h0B, 8'h00, 1'b0, 0, `ACX_ST_BADTYPE, 32'h55);
        cmd(8'h25, 8'h00, 8'h00, 1'b0, 0, `ACX_ST_BADOP, 32'h55);
        cmd(`ACX_OP_CLE, 8'h06, 8'h00, 1'b0, 0, `ACX_ST_BADTYPE, 32'h55);
        wb(1'b0, `ACX_R_STATE, 32'h0);
        chk(rd, {24'h0, `ACX_ST_BADTYPE});
    endtask
    task t_xfer;
        @(posedge clk_i);
        accu_load_i <= 1'b1;
        accu_load_val_i <= 32'hCAFE_0123;
        @(posedge clk_i);
        accu_load_i <= 1'b0;
        pgm(`ACX_OP_AXP, 8'h04, 8'h00);
        chk({14'h0, cap_sel}, {14'h0, 2'h1, 16'h0400});
        chk(cap_dat, 32'hCAFE_0123);
        pgm(`ACX_OP_GLP, 8'h11, 8'h03);
        chk({14'h0, cap_sel}, {14'h0, 2'h2, 16'h1103});
        wb(1'b1, `ACX_R_ACCU, 32'h8000_0001);
        cmd(`ACX_OP_GLP, 8'h2A, 8'h02, 1'b0, 2, `ACX_ST_OK, 32'h8000_0001);
        chk({14'h0, cap_sel}, {14'h0, 2'h2, 16'h2A02});
        chk(cap_dat, 32'h8000_0001);
        cmd(`ACX_OP_AXP, 8'h07, 8'h01, 1'b0, 0, `ACX_ST_OK, 32'h8000_0001);
        chk({14'h0, cap_sel}, {14'h0, 2'h1, 16'h0701});
    endtask
    task t_cle;
        logic [4:0] e;
        wb(1'b1, `ACX_R_ACCU, 32'h0);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            err_set_i <= 5'h1F;
            @(posedge clk_i);
            err_set_i <= 5'h00;
            e = (k == 0) ? 5'h00 : (5'h1F & ~(5'h01 << (k - 1)));
            cmd(`ACX_OP_CLE, k[7:0], 8'hA5, 1'b0, 1, `ACX_ST_OK, 32'h0);
            chk({27'h0, err_flags_o}, {27'h0, e});
        end
        wb(1'b1, `ACX_R_ERRF, 32'h3);
        chk({27'h0, err_flags_o}, 32'hC);
    endtask
    // raise, mask, clear; a zero divisor leaves the accumulator alone
    task t_irq;
        wb(1'b1, `ACX_R_ISTAT, 32'hF);
        wb(1'b1, `ACX_R_ACCU, 32'h9);
        wb(1'b1, `ACX_R_XREG, 32'h0);
        cmd(`ACX_OP_XCALC, `ACX_T_DIV, 8'h00, 1'b0, 0, `ACX_ST_OK, 32'h9);
        wb(1'b0, `ACX_R_ISTAT, 32'h0);
        chk(rd, 32'h9);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, `ACX_R_IMASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, `ACX_R_ISTAT, 32'h9);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_xcalc();
        t_refused();
        t_xfer();
        t_cle();
        t_irq();
        end_sim();
    end
endmodule
